//--- common/lcell_pkg.sv
package lcell_pkg;
  // ==========================================================================
  // Register map (byte offsets on the Avalon-MM slave).
  localparam int unsigned ADDR_W     = 4;
  localparam logic [3:0]  OFF_CTRL   = 4'h0;
  localparam logic [3:0]  OFF_LUT_FG = 4'h4;
  localparam logic [3:0]  OFF_LUT_H  = 4'h8;
  localparam logic [3:0]  OFF_STATUS = 4'hC;
  // ==========================================================================
  // Control register field positions.
  localparam int unsigned CTL_RAM_EN = 0;
  localparam int unsigned CTL_ORG    = 1;
  localparam int unsigned CTL_X_SEL  = 2;
  localparam int unsigned CTL_Y_SEL  = 3;
  localparam int unsigned CTL_XQ_SRC = 4;
  localparam int unsigned CTL_YQ_SRC = 6;
  localparam int unsigned CTL_CARRY  = 8;
  localparam int unsigned CTL_DIR    = 10;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_07FF;
  // ==========================================================================
  // Reset values and table sizes.
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [15:0] LUT_F_RST  = 16'h0000;
  localparam logic [15:0] LUT_G_RST  = 16'h0000;
  localparam logic [7:0]  LUT_H_RST  = 8'h00;
  localparam int unsigned TBL_DEPTH  = 16;
  localparam int unsigned TBL_AW     = 4;
  localparam int unsigned H_DEPTH    = 8;
  // ==========================================================================
  // Flip-flop source choice and carry mode.
  typedef enum logic [1:0] {LC_SRC_GEN, LC_SRC_H, LC_SRC_DIN, LC_SRC_ALT} lcell_src_t;
  typedef enum logic [1:0] {LC_CARRY_OFF, LC_CARRY_ONE, LC_CARRY_TWO, LC_CARRY_RSVD} lcell_carry_t;
endpackage : lcell_pkg

//--- common/lcell_tbl_if.sv
`timescale 1ns/1ps
interface lcell_tbl_if;
  logic [lcell_pkg::TBL_AW-1:0] f_addr;
  logic [lcell_pkg::TBL_AW-1:0] g_addr;
  logic                         f_we;
  logic                         g_we;
  logic                         f_wd;
  logic                         g_wd;
  logic                         cfg_we;
  logic [31:0]                  cfg_data;
  logic                         f_rd;
  logic                         g_rd;
  logic [31:0]                  tbl;
  modport ctl   (output f_addr, g_addr, f_we, g_we, f_wd, g_wd, cfg_we, cfg_data, input f_rd, g_rd, tbl);
  modport store (input f_addr, g_addr, f_we, g_we, f_wd, g_wd, cfg_we, cfg_data, output f_rd, g_rd, tbl);
endinterface : lcell_tbl_if

//--- hdl/lcell_lut_store.sv
`timescale 1ns/1ps
module lcell_lut_store #(
  parameter int unsigned DEPTH = lcell_pkg::TBL_DEPTH
) (
  input  wire logic    core_clk,
  input  wire logic    resetn,
  lcell_tbl_if.store   tbl_if
);
  logic [DEPTH-1:0] f_tbl_q;
  logic [DEPTH-1:0] g_tbl_q;

  // ==========================================================================
  // Table storage: bus loads both tables whole, the write strobe one entry.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      f_tbl_q <= lcell_pkg::LUT_F_RST;
    end else if (tbl_if.f_we) begin
      f_tbl_q[tbl_if.f_addr] <= tbl_if.f_wd;
    end else if (tbl_if.cfg_we) begin
      f_tbl_q <= tbl_if.cfg_data[DEPTH-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      g_tbl_q <= lcell_pkg::LUT_G_RST;
    end else if (tbl_if.g_we) begin
      g_tbl_q[tbl_if.g_addr] <= tbl_if.g_wd;
    end else if (tbl_if.cfg_we) begin
      g_tbl_q <= tbl_if.cfg_data[2*DEPTH-1:DEPTH];
    end
  end

  // Reads are pure look-ups of the current address, as in logic mode.
  assign tbl_if.f_rd = f_tbl_q[tbl_if.f_addr];
  assign tbl_if.g_rd = g_tbl_q[tbl_if.g_addr];
  assign tbl_if.tbl  = {g_tbl_q, f_tbl_q};
endmodule : lcell_lut_store

//--- hdl/lcell_top.sv
`timescale 1ns/1ps
// Contract
// - F and G tables each have their own four inputs.
// - H table combines F, G and the extra input.
// - F, G and H together realise any function of five inputs.
// - Each flip-flop can store a generator output or the direct data pin.
// - Extra input can bypass H to feed the Y flip-flop directly.
// - Separate combinational and registered output pairs, usable together.
// - Carry logic gives one or two arithmetic bits per cell.
// - Carry runs upward or downward along the column, selectable.
// - RAM mode makes the tables writable storage.
// - RAM organised 16 words by 2 bits or 32 words by 1 bit.
// - Table inputs serve as the word address in RAM mode.
// - 16x2 writes take data from the direct pin and extra input.
// - 32x1 writes take the direct pin; fifth address pin adds a bit.
// - Set/reset pin acts as the write strobe in RAM mode.
// - Read data on F and G in 16x2, on H in 32x1.
// - RAM read data still drive output pins or the flip-flops.
// - In 16x2 the H table still combines both read outputs.
// - In 32x1 flip-flops can catch read data and write data.
module lcell_top (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [3:0]  f_in,
  input  wire logic [3:0]  g_in,
  input  wire logic        extra_input,
  input  wire logic        din,
  input  wire logic        set_reset,
  input  wire logic        fifth_address_pin,
  input  wire logic        carry_from_below,
  input  wire logic        carry_from_above,
  output logic             carry_to_above,
  output logic             carry_to_below,
  output logic             x_out,
  output logic             y_out,
  output logic             xq_out,
  output logic             yq_out
);
  lcell_tbl_if tbl_if ();

  logic [31:0]                ctrl_q;
  logic [lcell_pkg::H_DEPTH-1:0] lut_h_q;
  logic                       ack_q;
  logic [31:0]                rdata_q;
  logic                       xq_q;
  logic                       yq_q;
  logic                       bus_req;
  logic                       bus_wr;
  logic [31:0]                rd_mux;
  logic                       ram_en;
  logic                       org32;
  lcell_pkg::lcell_src_t      xq_src;
  lcell_pkg::lcell_src_t      yq_src;
  lcell_pkg::lcell_carry_t    carry_mode;
  logic                       carry_down;
  logic                       carry_in;
  logic                       carry_mid;
  logic                       carry_out;
  logic                       f_val;
  logic                       g_val;
  logic                       h_val;
  logic                       ram_wr;

  // ==========================================================================
  // Avalon-MM slave: one wait cycle, then the answer.
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction : be_merge

  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_q;
  assign bus_wr          = avs_write & ack_q;
  assign avs_readdata    = rdata_q;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req & ~ack_q;
    end
  end

  always_comb begin
    case (avs_address)
      lcell_pkg::OFF_CTRL:   rd_mux = ctrl_q;
      lcell_pkg::OFF_LUT_FG: rd_mux = tbl_if.tbl;
      lcell_pkg::OFF_LUT_H:  rd_mux = {24'h00_0000, lut_h_q};
      lcell_pkg::OFF_STATUS: rd_mux = {25'h000_0000, yq_q, xq_q, y_out, x_out, h_val, g_val, f_val};
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read & ~ack_q) begin
      rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_q <= lcell_pkg::CTRL_RST;
    end else if (bus_wr && avs_address == lcell_pkg::OFF_CTRL) begin
      ctrl_q <= be_merge(ctrl_q, avs_writedata, avs_byteenable) & lcell_pkg::CTRL_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      lut_h_q <= lcell_pkg::LUT_H_RST;
    end else if (bus_wr && avs_address == lcell_pkg::OFF_LUT_H) begin
      lut_h_q <= avs_writedata[lcell_pkg::H_DEPTH-1:0];
    end
  end

  // ==========================================================================
  // Configuration decode.
  assign ram_en     = ctrl_q[lcell_pkg::CTL_RAM_EN];
  assign org32      = ctrl_q[lcell_pkg::CTL_ORG];
  assign xq_src     = lcell_pkg::lcell_src_t'(ctrl_q[lcell_pkg::CTL_XQ_SRC +: 2]);
  assign yq_src     = lcell_pkg::lcell_src_t'(ctrl_q[lcell_pkg::CTL_YQ_SRC +: 2]);
  assign carry_mode = lcell_pkg::lcell_carry_t'(ctrl_q[lcell_pkg::CTL_CARRY +: 2]);
  assign carry_down = ctrl_q[lcell_pkg::CTL_DIR];

  // ==========================================================================
  // Carry chain: the carry replaces the top table input so the tables form sums.
  assign carry_in  = carry_down ? carry_from_above : carry_from_below;
  assign carry_mid = (f_in[0] & f_in[1]) | (carry_in & (f_in[0] ^ f_in[1]));
  always_comb begin
    case (carry_mode)
      lcell_pkg::LC_CARRY_ONE: carry_out = carry_mid;
      lcell_pkg::LC_CARRY_TWO: carry_out = (g_in[0] & g_in[1]) | (carry_mid & (g_in[0] ^ g_in[1]));
      default:                 carry_out = 1'b0;
    endcase
  end
  assign carry_to_above = ~carry_down & carry_out;
  assign carry_to_below = carry_down & carry_out;

  // ==========================================================================
  // Table addressing and writes.
  always_comb begin
    tbl_if.f_addr = f_in;
    tbl_if.g_addr = g_in;
    if (!ram_en && carry_mode != lcell_pkg::LC_CARRY_OFF) begin
      tbl_if.f_addr[3] = carry_in;
      if (carry_mode == lcell_pkg::LC_CARRY_TWO) begin
        tbl_if.g_addr[3] = carry_mid;
      end
    end
  end

  assign ram_wr          = ram_en & set_reset;
  assign tbl_if.f_we     = ram_wr & (~org32 | ~fifth_address_pin);
  assign tbl_if.g_we     = ram_wr & (~org32 | fifth_address_pin);
  assign tbl_if.f_wd     = din;
  assign tbl_if.g_wd     = org32 ? din : extra_input;
  assign tbl_if.cfg_we   = bus_wr && avs_address == lcell_pkg::OFF_LUT_FG;
  assign tbl_if.cfg_data = be_merge(tbl_if.tbl, avs_writedata, avs_byteenable);

  lcell_lut_store #(
    .DEPTH (lcell_pkg::TBL_DEPTH)
  ) u_store (
    .core_clk (core_clk),
    .resetn   (resetn),
    .tbl_if   (tbl_if)
  );

  // ==========================================================================
  // Function generators and outputs.
  assign f_val = tbl_if.f_rd;
  assign g_val = tbl_if.g_rd;
  always_comb begin
    if (ram_en && org32) begin
      h_val = fifth_address_pin ? g_val : f_val;
    end else begin
      h_val = lut_h_q[{extra_input, g_val, f_val}];
    end
  end

  assign x_out = ctrl_q[lcell_pkg::CTL_X_SEL] ? h_val : f_val;
  assign y_out = ctrl_q[lcell_pkg::CTL_Y_SEL] ? h_val : g_val;
  assign xq_out = xq_q;
  assign yq_out = yq_q;

  // In logic mode the set/reset pin clears both flip-flops.
  always_ff @(posedge core_clk) begin
    if (!resetn || (!ram_en && set_reset)) begin
      xq_q <= 1'b0;
    end else begin
      case (xq_src)
        lcell_pkg::LC_SRC_GEN: xq_q <= f_val;
        lcell_pkg::LC_SRC_H:   xq_q <= h_val;
        lcell_pkg::LC_SRC_DIN: xq_q <= din;
        lcell_pkg::LC_SRC_ALT: xq_q <= g_val;
        default:               xq_q <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn || (!ram_en && set_reset)) begin
      yq_q <= 1'b0;
    end else begin
      case (yq_src)
        lcell_pkg::LC_SRC_GEN: yq_q <= g_val;
        lcell_pkg::LC_SRC_H:   yq_q <= h_val;
        lcell_pkg::LC_SRC_DIN: yq_q <= din;
        lcell_pkg::LC_SRC_ALT: yq_q <= extra_input;
        default:               yq_q <= 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  sequence s_req_wait;
    bus_req && avs_waitrequest;
  endsequence
  sequence s_req_done;
    bus_req && !avs_waitrequest;
  endsequence

  property p_bus_answer;
    s_req_wait |=> s_req_done or !bus_req;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus request not answered in one wait cycle");

  property p_ctrl_write;
    (avs_write && ack_q && avs_address == lcell_pkg::OFF_CTRL && avs_byteenable == 4'hF)
      |=> ctrl_q == ($past(avs_writedata) & lcell_pkg::CTRL_MASK);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write not stored");

  property p_ram_write16;
    (ram_en && !org32 && set_reset) ##1 (ram_en && !org32 && f_in == $past(f_in) && g_in == $past(g_in))
      |-> f_val == $past(din, 1) && g_val == $past(extra_input, 1);
  endproperty
  a_ram_write16: assert property (p_ram_write16) else $error("16x2 write data not read back");

  property p_ram_write32;
    (ram_en && org32 && set_reset) ##1 (ram_en && org32 && $stable(f_in) && $stable(g_in)
      && $stable(fifth_address_pin)) |-> h_val == $past(din);
  endproperty
  a_ram_write32: assert property (p_ram_write32) else $error("32x1 write data not read back");

  property p_ram_no_clear;
    (ram_en && set_reset && xq_src == lcell_pkg::LC_SRC_DIN) |=> xq_out == $past(din);
  endproperty
  a_ram_no_clear: assert property (p_ram_no_clear) else $error("strobe cleared flip-flop in ram mode");

  property p_logic_clear;
    (!ram_en && set_reset) |=> !xq_out && !yq_out;
  endproperty
  a_logic_clear: assert property (p_logic_clear) else $error("set/reset did not clear flip-flops");

  property p_extra_bypass;
    (!(!ram_en && set_reset) && yq_src == lcell_pkg::LC_SRC_ALT) |=> yq_out == $past(extra_input);
  endproperty
  a_extra_bypass: assert property (p_extra_bypass) else $error("extra input not passed to flip-flop");

  property p_carry_two;
    (carry_mode == lcell_pkg::LC_CARRY_TWO)
      |-> (carry_to_above | carry_to_below) == (({2'b00, f_in[0]} + {2'b00, f_in[1]} + {2'b00, carry_in}
                                                 + {1'b0, g_in[0], 1'b0} + {1'b0, g_in[1], 1'b0}) > 3'h3);
  endproperty
  a_carry_two: assert property (p_carry_two) else $error("two-bit carry out wrong");

  property p_carry_dir;
    carry_down |-> !carry_to_above;
  endproperty
  a_carry_dir: assert property (p_carry_dir) else $error("carry left in the wrong direction");
endmodule : lcell_top

//--- tb/lcell_user_model.sv
`timescale 1ns/1ps
module lcell_user_model (
  input  wire logic       core_clk,
  output logic      [3:0] f_in,
  output logic      [3:0] g_in,
  output logic            extra_input,
  output logic            din,
  output logic            set_reset,
  output logic            fifth_address_pin
);
  initial begin
    f_in = 4'h0;
    g_in = 4'h0;
    extra_input = 1'b0;
    din = 1'b0;
    set_reset = 1'b0;
    fifth_address_pin = 1'b0;
  end
  // ==========================================================================
  // Pin driver: every pin moves only just after a rising edge.
  task automatic drive(input logic [3:0] f, input logic [3:0] g, input logic e, input logic d,
                       input logic sr, input logic a5);
    @(posedge core_clk);
    f_in <= f;
    g_in <= g;
    extra_input <= e;
    din <= d;
    set_reset <= sr;
    fifth_address_pin <= a5;
  endtask : drive
  // ==========================================================================
  // One write: strobe high for one whole cycle while address and data hold still.
  task automatic ram_write(input logic a5, input logic [3:0] a, input logic d, input logic e);
    drive(a, a, e, d, 1'b1, a5);
    drive(a, a, e, d, 1'b0, a5);
  endtask : ram_write
endmodule : lcell_user_model

//--- tb/lcell_top_tb.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH %s expected %0h seen %0h", what, exp, got); end end
module lcell_top_tb;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  f_in, g_in;
  logic        extra_input, din, set_reset, fifth_address_pin;
  logic        carry_from_below = 1'b0;
  logic        carry_from_above = 1'b0;
  logic        carry_to_above, carry_to_below, x_out, y_out, xq_out, yq_out;
  int          errors = 0;
  int          comparisons = 0;
  int          cycles = 0;

  lcell_top lcell_top_inst (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .f_in(f_in), .g_in(g_in), .extra_input(extra_input), .din(din), .set_reset(set_reset),
    .fifth_address_pin(fifth_address_pin), .carry_from_below(carry_from_below),
    .carry_from_above(carry_from_above), .carry_to_above(carry_to_above), .carry_to_below(carry_to_below),
    .x_out(x_out), .y_out(y_out), .xq_out(xq_out), .yq_out(yq_out));
  lcell_user_model lcell_user_model_inst (.core_clk(core_clk), .f_in(f_in), .g_in(g_in),
    .extra_input(extra_input), .din(din), .set_reset(set_reset), .fifth_address_pin(fifth_address_pin));

  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // ==========================================================================
  // Hang guard and closing report.
  task automatic wrap_up;
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      wrap_up();
    end
  end
  // ==========================================================================
  // Avalon-MM master; waitrequest and read data are taken at the rising edge that ends the request.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, input logic [3:0] be,
                     output logic [31:0] rd);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    logic [31:0] d;
    bus(1'b1, a, v, 4'hF, d);
  endtask : wr
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, 4'hF, d);
    `CHK(what, exp, d)
  endtask : rd_chk
  task automatic pins(input logic [3:0] f, input logic [3:0] g, input logic e, input logic d,
                      input logic sr, input logic a5);
    lcell_user_model_inst.drive(f, g, e, d, sr, a5);
    // One more edge so the flip-flops have taken the new pin values.
    @(posedge core_clk);
    @(negedge core_clk);
  endtask : pins
  // ==========================================================================
  // Scenarios.
  task automatic t_regs;
    logic [31:0] d;
    rd_chk(lcell_pkg::OFF_CTRL, lcell_pkg::CTRL_RST, "ctrl reset");
    rd_chk(lcell_pkg::OFF_LUT_FG, {lcell_pkg::LUT_G_RST, lcell_pkg::LUT_F_RST}, "fg reset");
    rd_chk(lcell_pkg::OFF_LUT_H, {24'h0, lcell_pkg::LUT_H_RST}, "h reset");
    wr(4'h2, 32'hFFFF_FFFF);
    rd_chk(4'h2, 32'h0, "unmapped read");
    rd_chk(lcell_pkg::OFF_CTRL, 32'h0, "ctrl after unmapped write");
    bus(1'b1, lcell_pkg::OFF_CTRL, 32'hFFFF_FFFF, 4'h1, d);
    rd_chk(lcell_pkg::OFF_CTRL, 32'h0000_00FF, "ctrl lane 0");
    wr(lcell_pkg::OFF_CTRL, 32'hFFFF_FFFF);
    rd_chk(lcell_pkg::OFF_CTRL, lcell_pkg::CTRL_MASK, "ctrl mask");
    $display("test regs done");
  endtask : t_regs
  task automatic t_logic;
    wr(lcell_pkg::OFF_CTRL, 32'h0);
    wr(lcell_pkg::OFF_LUT_FG, 32'hFFFE_8000);
    wr(lcell_pkg::OFF_LUT_H, 32'h0000_0096);
    pins(4'hF, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    `CHK("x and4", 1'b1, x_out)
    `CHK("y or4", 1'b0, y_out)
    pins(4'hE, 4'h1, 1'b0, 1'b0, 1'b0, 1'b0);
    `CHK("x and4 b", 1'b0, x_out)
    `CHK("y or4 b", 1'b1, y_out)
    wr(lcell_pkg::OFF_CTRL, 32'h0000_000C);
    for (int e = 0; e < 2; e++) begin
      pins(4'h0, 4'h1, e[0], 1'b0, 1'b0, 1'b0);
      `CHK("x parity", ~e[0], x_out)
      `CHK("y parity", ~e[0], y_out)
    end
    rd_chk(lcell_pkg::OFF_STATUS, 32'h0000_0042, "status");
    $display("test logic done");
  endtask : t_logic
  task automatic t_flops;
    wr(lcell_pkg::OFF_CTRL, 32'h0000_00E0);
    pins(4'h0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0);
    `CHK("xq din", 1'b1, xq_out)
    `CHK("yq extra", 1'b0, yq_out)
    `CHK("x comb", 1'b0, x_out)
    pins(4'h0, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0);
    `CHK("xq din b", 1'b0, xq_out)
    `CHK("yq extra b", 1'b1, yq_out)
    pins(4'h0, 4'h0, 1'b1, 1'b1, 1'b1, 1'b0);
    `CHK("yq clear", 1'b0, yq_out)
    pins(4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    $display("test flops done");
  endtask : t_flops
  task automatic t_ram16;
    wr(lcell_pkg::OFF_LUT_H, 32'h0000_0088);
    wr(lcell_pkg::OFF_CTRL, 32'h0000_0009);
    lcell_user_model_inst.ram_write(1'b0, 4'h5, 1'b1, 1'b1);
    lcell_user_model_inst.ram_write(1'b0, 4'h6, 1'b1, 1'b0);
    pins(4'h5, 4'h5, 1'b0, 1'b0, 1'b0, 1'b0);
    `CHK("x ram 5", 1'b1, x_out)
    `CHK("y and 5", 1'b1, y_out)
    pins(4'h6, 4'h6, 1'b0, 1'b0, 1'b0, 1'b0);
    `CHK("x ram 6", 1'b1, x_out)
    `CHK("y and 6", 1'b0, y_out)
    rd_chk(lcell_pkg::OFF_LUT_FG, 32'hFFBE_8060, "fg after ram writes");
    $display("test ram16 done");
  endtask : t_ram16
  task automatic t_ram32;
    wr(lcell_pkg::OFF_CTRL, 32'h0000_0027);
    lcell_user_model_inst.ram_write(1'b1, 4'h0, 1'b1, 1'b0);
    @(negedge core_clk);
    `CHK("xq write data", 1'b1, xq_out)
    pins(4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b1);
    `CHK("h upper half", 1'b1, x_out)
    pins(4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    `CHK("h lower half", 1'b0, x_out)
    rd_chk(lcell_pkg::OFF_LUT_FG, 32'hFFBF_8060, "fg after 32x1 write");
    $display("test ram32 done");
  endtask : t_ram32
  task automatic t_carry;
    wr(lcell_pkg::OFF_CTRL, 32'h0000_0100);
    pins(4'h3, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    `CHK("carry up", 1'b1, carry_to_above)
    `CHK("carry up other side", 1'b0, carry_to_below)
    wr(lcell_pkg::OFF_CTRL, 32'h0000_0500);
    @(negedge core_clk);
    `CHK("carry down", 1'b1, carry_to_below)
    `CHK("carry down other side", 1'b0, carry_to_above)
    pins(4'h0, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    `CHK("no carry", 1'b0, carry_to_below)
    wr(lcell_pkg::OFF_CTRL, 32'h0000_0200);
    carry_from_below <= 1'b1;
    pins(4'h1, 4'h1, 1'b0, 1'b0, 1'b0, 1'b0);
    `CHK("two-bit carry from below", 1'b1, carry_to_above)
    @(posedge core_clk);
    carry_from_below <= 1'b0;
    @(negedge core_clk);
    `CHK("two-bit carry blocked", 1'b0, carry_to_above)
    wr(lcell_pkg::OFF_CTRL, 32'h0000_0600);
    carry_from_above <= 1'b1;
    @(negedge core_clk);
    `CHK("two-bit carry from above", 1'b1, carry_to_below)
    `CHK("two-bit carry not upward", 1'b0, carry_to_above)
    $display("test carry done");
  endtask : t_carry
  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_logic();
    t_flops();
    t_ram16();
    t_ram32();
    t_carry();
    wrap_up();
  end
endmodule : lcell_top_tb
